// ===== rtl/mode_ctrl_pkg.sv
// Purpose: Shared constants and types for the transceiver mode controller
// Assumes: 20 MHz ref_clk
// Notes:   Register map, timer figures and mode codes
package mode_ctrl_pkg;

	// ==========================================================
	// Clock and timers
	// ==========================================================
	localparam int unsigned CLK_HZ              = 20000000;
	localparam int unsigned SLEEP_ENTRY_US      = 50;      // Least go-to-sleep hold
	localparam int unsigned INACTIVITY_LIMIT_S  = 240;     // Fallback to sleep
	localparam int unsigned TX_DOM_TIMEOUT_US   = 1200;    // Longest dominant drive
	localparam longint unsigned SLEEP_ENTRY_CYC =
		(longint'(SLEEP_ENTRY_US) * CLK_HZ + 999999) / 1000000;
	localparam longint unsigned INACTIVITY_CYC  = longint'(INACTIVITY_LIMIT_S) * CLK_HZ;
	localparam longint unsigned TX_DOM_CYC      =
		longint'(TX_DOM_TIMEOUT_US) * CLK_HZ / 1000000;
	localparam int unsigned CNT_W               = 33;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_STATUS   = 12'h004;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFF_IRQ_EN   = 12'h00c;
	localparam logic [11:0] OFF_IRQ_CLR  = 12'h010;

	localparam int unsigned CTRL_STB_BIT  = 0;
	localparam int unsigned CTRL_SEL_BIT  = 1;
	localparam int unsigned CTRL_OVR_BIT  = 2;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;

	// Event bit positions in irq status/enable/clear registers
	localparam int unsigned EV_MODE   = 0;
	localparam int unsigned EV_WAKE   = 1;
	localparam int unsigned EV_TXDTO  = 2;
	localparam int unsigned EV_FALLBK = 3;
	localparam int unsigned EV_W      = 4;

	typedef enum logic [2:0] {
		MODE_OFF     = 3'b000,
		MODE_NORMAL  = 3'b001,
		MODE_SILENT  = 3'b010,
		MODE_STANDBY = 3'b011,
		MODE_GOSLEEP = 3'b100,
		MODE_SLEEP   = 3'b101
	} mode_e;

endpackage : mode_ctrl_pkg

// ===== rtl/sync2.sv
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Inputs asynchronous to ref_clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] reset_val,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_s;

	sync_s state;
	sync_s next_state;

	// Shift the stages
	always_comb begin
		next_state.meta   = async_in;
		next_state.stable = state.meta;
		if (srst) begin
			next_state.meta   = reset_val;
			next_state.stable = reset_val;
		end
	end

	// Register stage pair
	always_ff @(posedge ref_clk) begin
		state <= next_state;
	end

	assign sync_out = state.stable;
endmodule : sync2

// ===== rtl/mode_ctrl.sv
// Purpose: Operating-mode controller of a CAN FD transceiver
// Assumes: 20 MHz ref_clk, synchronous active-high srst, APB slave
// Notes:   Pin levels pass through sync2 before use
`timescale 1ns/1ps
module mode_ctrl #(
	parameter longint unsigned SLEEP_ENTRY_CNT = mode_ctrl_pkg::SLEEP_ENTRY_CYC,
	parameter longint unsigned INACTIVITY_CNT  = mode_ctrl_pkg::INACTIVITY_CYC,
	parameter longint unsigned TX_DOM_CNT      = mode_ctrl_pkg::TX_DOM_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins and status inputs
	input  wire logic        standby_bar_pin,
	input  wire logic        mode_select_pin,
	input  wire logic        txd_pin,
	input  wire logic        bus_rx,
	input  wire logic        bus_wake,
	input  wire logic        local_wake_event,
	input  wire logic        battery_undervoltage,
	input  wire logic        core_supply_undervoltage,
	input  wire logic        io_supply_undervoltage,
	input  wire logic        local_failure,
	// Outputs
	output logic             driver_en,
	output logic             driver_tx,
	output logic             receiver_en,
	output logic             monitor_en,
	output logic             rxd_out,
	output logic             rxd_oe,
	output logic             system_supply_switch,
	output logic             system_supply_switch_oe,
	output logic             fault_indicator_pin,
	output logic             irq
);
	localparam int unsigned EW = mode_ctrl_pkg::EV_W;
	localparam int unsigned CW = mode_ctrl_pkg::CNT_W;

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [9:0] pins;
	sync2 #(.W(10)) u_sync (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.async_in  ({standby_bar_pin, mode_select_pin, txd_pin, bus_rx, bus_wake,
			local_wake_event, battery_undervoltage, core_supply_undervoltage,
			io_supply_undervoltage, local_failure}),
		.reset_val (10'h080),
		.sync_out  (pins)
	);
	logic s_stb, s_sel, s_txd, s_rx, s_bwake, s_lwake;
	logic s_uvbat, s_uvcore, s_uvlogic, s_lfail;
	assign {s_stb, s_sel, s_txd, s_rx, s_bwake, s_lwake, s_uvbat, s_uvcore, s_uvlogic,
		s_lfail} = pins;

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		mode_ctrl_pkg::mode_e mode;
		logic                 wake_request_flag;
		logic                 power_up_flag;
		logic                 fallback_run;
		logic [CW-1:0]        sleep_fallback_timer;
		logic [CW-1:0]        sleep_entry_cnt;
		logic [CW-1:0]        dom_cnt;
		logic                 dom_lock;
		logic                 stb_prev;
		logic [2:0]           ctrl;
		logic [EW-1:0]        irq_stat;
		logic [EW-1:0]        irq_en;
		logic [31:0]          rdata;
	} state_s;

	state_s state;
	state_s next_state;

	logic eff_stb, eff_sel, wr_acc, rd_acc, entry_done, fb_done, dom_done;

	// Effective mode request: control register may override pins
	assign eff_stb    = state.ctrl[mode_ctrl_pkg::CTRL_OVR_BIT] ?
		state.ctrl[mode_ctrl_pkg::CTRL_STB_BIT] : s_stb;
	assign eff_sel    = state.ctrl[mode_ctrl_pkg::CTRL_OVR_BIT] ?
		state.ctrl[mode_ctrl_pkg::CTRL_SEL_BIT] : s_sel;
	assign wr_acc     = psel && penable && pwrite;
	assign rd_acc     = psel && !penable && !pwrite;
	assign entry_done = state.sleep_entry_cnt >= CW'(SLEEP_ENTRY_CNT - 1);
	assign fb_done    = state.sleep_fallback_timer >= CW'(INACTIVITY_CNT - 1);
	assign dom_done   = state.dom_cnt >= CW'(TX_DOM_CNT - 1);

	// Next state
	always_comb begin
		logic [EW-1:0] ev;
		mode_ctrl_pkg::mode_e nm;
		ev = '0;
		nm = state.mode;
		next_state = state;
		next_state.stb_prev = eff_stb;
		if (s_uvbat) begin
			nm = mode_ctrl_pkg::MODE_OFF;
		end else begin
			unique case (state.mode)
				mode_ctrl_pkg::MODE_OFF: begin
					nm = mode_ctrl_pkg::MODE_STANDBY;
				end
				mode_ctrl_pkg::MODE_SLEEP: begin
					if (s_bwake || s_lwake || (eff_stb && !state.stb_prev))
						nm = mode_ctrl_pkg::MODE_STANDBY;
				end
				default: begin
					if (eff_stb && eff_sel) nm = mode_ctrl_pkg::MODE_NORMAL;
					else if (eff_stb) nm = mode_ctrl_pkg::MODE_SILENT;
					else if (!eff_sel || state.wake_request_flag)
						nm = mode_ctrl_pkg::MODE_STANDBY;
					else nm = mode_ctrl_pkg::MODE_GOSLEEP;
					if (state.mode == mode_ctrl_pkg::MODE_GOSLEEP &&
						nm == mode_ctrl_pkg::MODE_GOSLEEP && entry_done)
						nm = mode_ctrl_pkg::MODE_SLEEP;
					if (state.fallback_run && fb_done &&
						nm != mode_ctrl_pkg::MODE_NORMAL)
						nm = mode_ctrl_pkg::MODE_SLEEP;
					if (s_uvcore || s_uvlogic) nm = mode_ctrl_pkg::MODE_STANDBY;
				end
			endcase
		end
		next_state.mode = nm;
		if (nm != state.mode) ev[mode_ctrl_pkg::EV_MODE] = 1'b1;
		// Sleep-entry timer
		if (state.mode == mode_ctrl_pkg::MODE_GOSLEEP && nm == mode_ctrl_pkg::MODE_GOSLEEP)
			next_state.sleep_entry_cnt = state.sleep_entry_cnt + 1'b1;
		else
			next_state.sleep_entry_cnt = '0;
		// fallback timer runs in standby and silent after standby
		if (nm == mode_ctrl_pkg::MODE_STANDBY) next_state.fallback_run = 1'b1;
		else if (nm != mode_ctrl_pkg::MODE_SILENT) next_state.fallback_run = 1'b0;
		if (state.fallback_run && nm != mode_ctrl_pkg::MODE_NORMAL)
			next_state.sleep_fallback_timer = state.sleep_fallback_timer + 1'b1;
		if (nm == mode_ctrl_pkg::MODE_NORMAL || !next_state.fallback_run)
			next_state.sleep_fallback_timer = '0;
		if (state.fallback_run && fb_done) ev[mode_ctrl_pkg::EV_FALLBK] = 1'b1;
		// Wake flag set wins over clear
		if (nm == mode_ctrl_pkg::MODE_NORMAL && state.mode != mode_ctrl_pkg::MODE_NORMAL) begin
			next_state.wake_request_flag = 1'b0;
			next_state.power_up_flag     = 1'b0;
		end
		if ((s_bwake || s_lwake) && state.mode inside {mode_ctrl_pkg::MODE_STANDBY,
			mode_ctrl_pkg::MODE_SLEEP, mode_ctrl_pkg::MODE_GOSLEEP}) begin
			next_state.wake_request_flag = 1'b1;
			ev[mode_ctrl_pkg::EV_WAKE] = 1'b1;
		end
		if (s_txd || state.mode != mode_ctrl_pkg::MODE_NORMAL) begin
			next_state.dom_cnt  = '0;
			next_state.dom_lock = 1'b0;
		end else if (dom_done) begin
			next_state.dom_lock = 1'b1;
			if (!state.dom_lock) ev[mode_ctrl_pkg::EV_TXDTO] = 1'b1;
		end else begin
			next_state.dom_cnt = state.dom_cnt + 1'b1;
		end
		// APB writes; hardware set wins over clear
		if (wr_acc) begin
			unique case (paddr)
				mode_ctrl_pkg::OFF_CTRL:   next_state.ctrl   = pwdata[2:0];
				mode_ctrl_pkg::OFF_IRQ_EN: next_state.irq_en = pwdata[EW-1:0];
				mode_ctrl_pkg::OFF_IRQ_CLR:
					next_state.irq_stat = state.irq_stat & ~pwdata[EW-1:0];
				default: ;
			endcase
		end
		next_state.irq_stat = next_state.irq_stat | ev;
		// APB read data captured in setup
		if (rd_acc) begin
			unique case (paddr)
				mode_ctrl_pkg::OFF_CTRL:     next_state.rdata = {29'h0, state.ctrl};
				mode_ctrl_pkg::OFF_STATUS:   next_state.rdata = {24'h0, state.dom_lock,
					state.power_up_flag, state.wake_request_flag, state.fallback_run,
					1'b0, state.mode};
				mode_ctrl_pkg::OFF_IRQ_STAT: next_state.rdata = {28'h0, state.irq_stat};
				mode_ctrl_pkg::OFF_IRQ_EN:   next_state.rdata = {28'h0, state.irq_en};
				default:                     next_state.rdata = 32'h0;
			endcase
		end
		if (srst) begin
			next_state = '0;
			next_state.mode          = mode_ctrl_pkg::MODE_OFF;
			next_state.power_up_flag = 1'b1;
			next_state.ctrl          = mode_ctrl_pkg::CTRL_RESET;
		end
	end

	// Register state
	always_ff @(posedge ref_clk) begin
		state <= next_state;
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	logic m_norm, m_sil, m_stby, m_gts, m_slp;
	assign m_norm = state.mode == mode_ctrl_pkg::MODE_NORMAL;
	assign m_sil  = state.mode == mode_ctrl_pkg::MODE_SILENT;
	assign m_stby = state.mode == mode_ctrl_pkg::MODE_STANDBY;
	assign m_gts  = state.mode == mode_ctrl_pkg::MODE_GOSLEEP;
	assign m_slp  = state.mode == mode_ctrl_pkg::MODE_SLEEP;

	assign driver_en   = m_norm && !state.dom_lock;
	assign driver_tx   = s_txd;
	assign receiver_en = m_norm || m_sil;
	assign monitor_en  = m_stby || m_gts || m_slp;
	assign rxd_oe  = !s_uvlogic && (receiver_en || monitor_en);
	assign rxd_out = receiver_en ? s_rx : !(m_stby && state.wake_request_flag);
	// supply switch, released in sleep and off
	assign system_supply_switch    = 1'b1;
	assign system_supply_switch_oe = m_norm || m_sil || m_stby || m_gts;
	// fault indicator active low in silent
	assign fault_indicator_pin = !(m_sil && (state.power_up_flag || s_lfail));
	assign irq     = |(state.irq_stat & state.irq_en);
	assign prdata  = state.rdata;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	chk_normal_clears: assert property (
		!m_norm ##1 m_norm |-> !state.power_up_flag) else $error("flags not cleared");
	chk_normal_timer: assert property (
		m_norm |-> state.sleep_fallback_timer == '0) else $error("fallback not reset");
	chk_sleep_switch: assert property (
		m_slp |-> !system_supply_switch_oe) else $error("supply switch on in sleep");
	chk_gts_switch: assert property (
		m_gts |-> system_supply_switch_oe && !driver_en) else $error("go-to-sleep outputs");
	chk_uvbat_off: assert property (
		s_uvbat |=> state.mode == mode_ctrl_pkg::MODE_OFF) else $error("undervoltage not off");
	chk_silent_drv: assert property (
		m_sil |-> !driver_en && receiver_en) else $error("silent gating");
	chk_dom_limit: assert property (
		state.dom_lock |-> !driver_en) else $error("dominant not limited");
	chk_fault_silent: assert property (
		m_sil && state.power_up_flag |-> !fault_indicator_pin) else $error("fault hidden");
	chk_standby_wake: assert property (
		m_stby && state.wake_request_flag && rxd_oe |-> !rxd_out) else $error("wake not shown");
	// Off and normal gating, fallback exit from silent
	chk_off_outputs: assert property (
		state.mode == mode_ctrl_pkg::MODE_OFF |-> !driver_en && !receiver_en && !rxd_oe &&
		!system_supply_switch_oe) else $error("off state outputs active");
	chk_normal_gating: assert property (
		m_norm && !state.dom_lock |-> driver_en && receiver_en && system_supply_switch_oe)
		else $error("normal gating");
	chk_silent_fallback: assert property (
		m_sil && state.fallback_run && fb_done && !s_uvbat && !s_uvcore && !s_uvlogic &&
		!(eff_stb && eff_sel) |=> m_slp) else $error("fallback expiry missed");

	cov_normal: cover property (!m_norm ##1 m_norm);
	cov_gts_sleep: cover property (m_gts ##1 m_slp);
	cov_fallback: cover property (m_sil ##1 m_slp);
	cov_wake: cover property (m_slp ##1 m_stby);
endmodule : mode_ctrl

// ===== sim/host_model.sv
// Purpose: Host controller model driving the mode and transmit pins
// Assumes: Bench sets wanted levels; pins change after a rising edge
// Notes:   A released host leaves pins to their fail-safe bias
`timescale 1ns/1ps
module host_model (
	input  wire logic ref_clk,
	input  wire logic released,
	input  wire logic want_stb,
	input  wire logic want_sel,
	input  wire logic want_txd,
	output logic      standby_bar_pin = 1'b0,
	output logic      mode_select_pin = 1'b0,
	output logic      txd_pin         = 1'b1
);
	// ==========================================================
	// Pin drivers
	// ==========================================================
	// bias and selection
	always @(posedge ref_clk) begin
		standby_bar_pin <= released ? 1'b0 : want_stb;
		mode_select_pin <= released ? 1'b0 : want_sel;
		txd_pin         <= released ? 1'b1 : want_txd;
	end
endmodule : host_model

// ===== sim/can_transceiver_mode_control_test.sv
// Purpose: Self-checking bench of the mode controller
// Assumes: 20 MHz ref_clk, short timer counts
// Notes:   Host model drives pins; status polled over APB
`timescale 1ns/1ps
module can_transceiver_mode_control_test;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, r;
	logic        pready, pslverr, released = 1'b1;
	logic        want_stb = 1'b0, want_sel = 1'b0, want_txd = 1'b1;
	logic        standby_bar_pin, mode_select_pin, txd_pin;
	logic        bus_rx = 1'b1, bus_wake = 1'b0, local_wake_event = 1'b0;
	logic        battery_undervoltage = 1'b0, core_supply_undervoltage = 1'b0;
	logic        io_supply_undervoltage = 1'b0, local_failure = 1'b0;
	logic        driver_en, driver_tx, receiver_en, monitor_en, rxd_out, rxd_oe;
	logic        system_supply_switch, system_supply_switch_oe, fault_indicator_pin, irq;
	int          err_count = 0;
	int          samples_checked = 0;

	// ==========================================================
	// Clock, host and design
	// ==========================================================
	// Free-running clock
	initial forever #25 ref_clk = ~ref_clk;
	host_model u_host_model (.ref_clk, .released, .want_stb, .want_sel, .want_txd,
		.standby_bar_pin, .mode_select_pin, .txd_pin);
	mode_ctrl #(.SLEEP_ENTRY_CNT(40), .INACTIVITY_CNT(60), .TX_DOM_CNT(10)) u_mode_ctrl (
		.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .standby_bar_pin, .mode_select_pin, .txd_pin, .bus_rx, .bus_wake,
		.local_wake_event, .battery_undervoltage, .core_supply_undervoltage,
		.io_supply_undervoltage, .local_failure, .driver_en, .driver_tx, .receiver_en,
		.monitor_en, .rxd_out, .rxd_oe, .system_supply_switch, .system_supply_switch_oe,
		.fault_indicator_pin, .irq);

	// ==========================================================
	// Checking and bus tasks
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp, input string msg);
		chk({31'h0, got}, {31'h0, exp}, msg);
	endtask : chk1

	task automatic complete_run();
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	// One APB transfer; read data lands in rd
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge ref_clk);
		end
		if (pready !== 1'b1) begin
			chk1(1'b0, 1'b1, "apb no ready");
			complete_run();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Expected {driver, receiver, monitor, supply switch enable}
	function automatic logic [3:0] exp_en(input mode_ctrl_pkg::mode_e m);
		case (m)
			mode_ctrl_pkg::MODE_NORMAL:  return 4'hd;
			mode_ctrl_pkg::MODE_SILENT:  return 4'h5;
			mode_ctrl_pkg::MODE_STANDBY: return 4'h3;
			mode_ctrl_pkg::MODE_GOSLEEP: return 4'h3;
			mode_ctrl_pkg::MODE_SLEEP:   return 4'h2;
			default:                     return 4'h0;
		endcase
	endfunction : exp_en

	task automatic chk_en(input mode_ctrl_pkg::mode_e m);
		chk({28'h0, driver_en, receiver_en, monitor_en, system_supply_switch_oe},
			{28'h0, exp_en(m)}, "mode enables");
	endtask : chk_en

	// Poll status until the mode shows, bounded
	task automatic wait_mode(input mode_ctrl_pkg::mode_e m, input int lim);
		int n;
		n = 0;
		do begin
			apb(1'b0, mode_ctrl_pkg::OFF_STATUS, 32'h0);
			n++;
		end while (rd[2:0] !== m && n < lim);
		chk({29'h0, rd[2:0]}, {29'h0, m}, "mode");
		// Bound used up: go to the verdict
		if (rd[2:0] !== m) complete_run();
	endtask : wait_mode

	// ==========================================================
	// Scenarios
	// ==========================================================
	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		chk1(1'b0, 1'b1, "run timeout");
		complete_run();
	end

	// Main sequence
	initial begin
		r = $urandom(32'h6ad9);
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		apb(1'b0, mode_ctrl_pkg::OFF_CTRL, 32'h0);
		chk(rd, {29'h0, mode_ctrl_pkg::CTRL_RESET}, "ctrl reset");
		apb(1'b0, mode_ctrl_pkg::OFF_STATUS, 32'h0);
		chk1(rd[6], 1'b1, "power-up flag after reset");
		wait_mode(mode_ctrl_pkg::MODE_SLEEP, 60);
		chk_en(mode_ctrl_pkg::MODE_SLEEP);
		released <= 1'b0;
		want_stb <= 1'b1;
		want_sel <= 1'b1;
		wait_mode(mode_ctrl_pkg::MODE_NORMAL, 30);
		chk_en(mode_ctrl_pkg::MODE_NORMAL);
		apb(1'b0, mode_ctrl_pkg::OFF_STATUS, 32'h0);
		chk({29'h0, rd[6:4]}, 32'h0, "flags and fallback on normal");
		for (int i = 0; i < 8; i++) begin
			r = $urandom();
			bus_rx <= r[0];
			want_txd <= r[1] | i[0];
			repeat (6) @(posedge ref_clk);
			chk1(rxd_out, r[0], "receive mirror");
			chk1(driver_tx, r[1] | i[0], "transmit path");
		end
		want_txd <= 1'b1;
		want_sel <= 1'b0;
		wait_mode(mode_ctrl_pkg::MODE_SILENT, 30);
		chk_en(mode_ctrl_pkg::MODE_SILENT);
		local_failure <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk1(fault_indicator_pin, 1'b0, "fault shown in silent");
		local_failure <= 1'b0;
		want_sel <= 1'b1;
		wait_mode(mode_ctrl_pkg::MODE_NORMAL, 30);
		apb(1'b1, mode_ctrl_pkg::OFF_IRQ_EN, 32'h0);
		apb(1'b1, mode_ctrl_pkg::OFF_IRQ_CLR, 32'hffffffff);
		want_txd <= 1'b0;
		repeat (30) @(posedge ref_clk);
		chk1(driver_en & ~driver_tx, 1'b0, "dominant drive cut");
		apb(1'b0, mode_ctrl_pkg::OFF_IRQ_STAT, 32'h0);
		chk1(rd[mode_ctrl_pkg::EV_TXDTO], 1'b1, "timeout event");
		chk1(irq, 1'b0, "masked interrupt");
		apb(1'b1, mode_ctrl_pkg::OFF_IRQ_EN, 32'h4);
		apb(1'b0, mode_ctrl_pkg::OFF_IRQ_EN, 32'h0);
		chk(rd, 32'h4, "enable readback");
		chk1(irq, 1'b1, "enabled interrupt");
		want_txd <= 1'b1;
		apb(1'b1, mode_ctrl_pkg::OFF_IRQ_CLR, 32'h4);
		apb(1'b0, mode_ctrl_pkg::OFF_IRQ_STAT, 32'h0);
		chk1(irq, 1'b0, "cleared interrupt");
		want_stb <= 1'b0;
		wait_mode(mode_ctrl_pkg::MODE_GOSLEEP, 10);
		chk_en(mode_ctrl_pkg::MODE_GOSLEEP);
		chk1(system_supply_switch, 1'b1, "supply switch level");
		wait_mode(mode_ctrl_pkg::MODE_SLEEP, 30);
		chk_en(mode_ctrl_pkg::MODE_SLEEP);
		local_wake_event <= 1'b1;
		repeat (4) @(posedge ref_clk);
		local_wake_event <= 1'b0;
		wait_mode(mode_ctrl_pkg::MODE_STANDBY, 10);
		chk_en(mode_ctrl_pkg::MODE_STANDBY);
		chk1(rd[5], 1'b1, "wake flag");
		chk1(rxd_out | ~rxd_oe, 1'b0, "wake shown low");
		want_stb <= 1'b1;
		want_sel <= 1'b0;
		wait_mode(mode_ctrl_pkg::MODE_SILENT, 10);
		chk1(rd[4], 1'b1, "fallback keeps running");
		wait_mode(mode_ctrl_pkg::MODE_SLEEP, 40);
		want_stb <= 1'b0;
		repeat (6) @(posedge ref_clk);
		want_stb <= 1'b1;
		want_sel <= 1'b1;
		wait_mode(mode_ctrl_pkg::MODE_NORMAL, 30);
		io_supply_undervoltage <= 1'b1;
		wait_mode(mode_ctrl_pkg::MODE_STANDBY, 10);
		chk1(rxd_oe, 1'b0, "receive released without io");
		io_supply_undervoltage <= 1'b0;
		battery_undervoltage <= 1'b1;
		wait_mode(mode_ctrl_pkg::MODE_OFF, 15);
		chk_en(mode_ctrl_pkg::MODE_OFF);
		chk1(rxd_oe, 1'b0, "receive released when off");
		battery_undervoltage <= 1'b0;
		apb(1'b1, 12'h020, 32'hffffffff);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		chk1(pslverr, 1'b0, "no slave error");
		complete_run();
	end
endmodule : can_transceiver_mode_control_test
